/* common/dtc_pkg.sv */
// Constants, field layout and types of the DRAM timing configuration block.
// Assumes a 32-bit APB master and a single 25 MHz system clock.
`default_nettype none

package dtc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register map
   localparam logic [31:0] DTC_MTC_ADDR  = 32'hffffffec;  // Control register byte address
   localparam logic [15:0] DTC_MTC_RESET = 16'h0000;      // Every field starts at zero
   localparam logic [15:0] DTC_MTC_WMASK = 16'hfefc;      // Bits 8, 1, 0 are reserved

   ////////////////////////////////////////////////////////////////////////////
   // Field positions inside the control register
   localparam int DTC_BIT_TRP   = 15;  // RAS precharge length
   localparam int DTC_BIT_RCD   = 14;  // RAS to CAS delay
   localparam int DTC_BIT_TWL   = 13;  // Write to precharge delay
   localparam int DTC_BIT_REFRESH_RAS_TIME_HI = 12;  // Refresh RAS time, high bit
   localparam int DTC_BIT_REFRESH_RAS_TIME_LO = 11;  // Refresh RAS time, low bit
   localparam int DTC_BIT_BURST = 10;  // Burst enable
   localparam int DTC_BIT_BANK  = 9;   // Bank active mode
   localparam int DTC_BIT_ADDR_MUX_SEL_2  = 7;   // Address multiplex, top bit
   localparam int DTC_BIT_SIZE  = 6;   // Memory data size
   localparam int DTC_BIT_ADDR_MUX_SEL_1  = 5;   // Address multiplex, middle bit
   localparam int DTC_BIT_ADDR_MUX_SEL_0  = 4;   // Address multiplex, low bit
   localparam int DTC_BIT_REFRESH_ENABLE  = 3;   // Refresh enable
   localparam int DTC_BIT_REFRESH_MODE_SELECT = 2;   // Refresh mode

   ////////////////////////////////////////////////////////////////////////////
   // Cycle counts
   typedef logic [2:0] dtc_cyc_t;
   localparam dtc_cyc_t DTC_CYC_SHORT = 3'h1;  // Timing bit clear
   localparam dtc_cyc_t DTC_CYC_LONG  = 3'h2;  // Timing bit set
   localparam dtc_cyc_t DTC_RAS_CYC0  = 3'h2;  // Refresh RAS code 00
   localparam dtc_cyc_t DTC_RAS_CYC1  = 3'h3;  // Refresh RAS code 01
   localparam dtc_cyc_t DTC_RAS_CYC2  = 3'h4;  // Refresh RAS code 10
   localparam logic [3:0] DTC_COL_BASE = 4'h8; // Column width for multiplex code 000

   ////////////////////////////////////////////////////////////////////////////
   // Memory type attached to an area
   typedef enum logic [1:0] {
      DTC_AREA_NORMAL = 2'h0,
      DTC_AREA_DRAM   = 2'h1,
      DTC_AREA_SDRAM  = 2'h2,
      DTC_AREA_PSRAM  = 2'h3
   } dtc_area_t;

endpackage

`default_nettype wire

/* design/dtc_refresh_ras.sv */
// CAS-before-RAS refresh RAS pulse generator.
// Assumes start is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module dtc_refresh_ras (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              reset,
   // Request and length
   input  wire logic              start,
   input  wire dtc_pkg::dtc_cyc_t rasCycles,
   // RAS drive
   output logic                   rasActive
);
   import dtc_pkg::*;

   // One-hot sequencer states
   typedef enum logic [1:0] {
      RS_IDLE = 2'b01,
      RS_RAS  = 2'b10
   } dtc_ras_state_t;

   // All state of the generator
   typedef struct packed {
      dtc_ras_state_t state;  // Sequencer state
      dtc_cyc_t       left;   // RAS cycles still to run
   } dtc_ras_t;

   dtc_ras_t st_reg;  // Registered state
   dtc_ras_t st_next; // Next state

   ////////////////////////////////////////////////////////////////////////////
   // Next state: a request while RAS is high is ignored, so pulses never merge
   always_comb begin
      st_next = st_reg;
      case (st_reg.state)
         RS_IDLE: begin
            if (start) begin
               st_next.state = RS_RAS;
               st_next.left  = rasCycles;
            end
         end
         RS_RAS: begin
            if (st_reg.left <= 3'h1) begin
               st_next.state = RS_IDLE;
               st_next.left  = 3'h0;
            end else begin
               st_next.left = st_reg.left - 3'h1;
            end
         end
         default: begin
            st_next.state = RS_IDLE;
            st_next.left  = 3'h0;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_reg <= '{state: RS_IDLE, left: 3'h0};
      end else begin
         st_reg <= st_next;
      end
   end

   // RAS straight from the state flop
   assign rasActive = (st_reg.state == RS_RAS);

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   chk_ras_two: assert property (@(posedge clk) disable iff (reset)
      (start && !rasActive && rasCycles == 3'h2) |=> rasActive[*2] ##1 !rasActive)
      else $error("refresh RAS not held two cycles");
   chk_ras_three: assert property (@(posedge clk) disable iff (reset)
      (start && !rasActive && rasCycles == 3'h3) |=> rasActive[*3] ##1 !rasActive)
      else $error("refresh RAS not held three cycles");
   chk_ras_four: assert property (@(posedge clk) disable iff (reset)
      (start && !rasActive && rasCycles == 3'h4) |=> rasActive[*4] ##1 !rasActive)
      else $error("refresh RAS not held four cycles");
   cov_ras_four: cover property (@(posedge clk) disable iff (reset)
      rasActive[*4]);

endmodule

`default_nettype wire

/* design/dtc_timing_config.sv */
// DRAM timing configuration: control register on APB and decoded settings.
// Assumes area types and refresh tick come from logic on the same clock.
//
// Function
// - Refresh RAS held two, three or four cycles
// - Burst bit gives DRAM page mode
// - Burst bit gives pseudo-SRAM static column mode
// - Synchronous DRAM always bursts
// - Bank mode clear: synchronous DRAM auto-precharges every access
// - Bank mode set: area 3 keeps bank active
// - Synchronous DRAM in area 2 always auto-precharges
// - DRAM column width from multiplex field
// - Synchronous DRAM geometry from multiplex field
// - Size bit selects word or longword
// - Refresh enable bit gates refresh cycles
// - Refresh mode selects normal or self-refresh
// - Reserved bits read zero, fields reset zero
`timescale 1ns/1ps
`default_nettype none

module dtc_timing_config (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               reset,
   // APB slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [31:0]        paddr,
   input  wire logic [31:0]        pwdata,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr,
   // Area memory types and refresh pacing
   input  wire dtc_pkg::dtc_area_t area2Type,
   input  wire dtc_pkg::dtc_area_t area3Type,
   input  wire logic               refreshTick,
   // Cycle timing
   output dtc_pkg::dtc_cyc_t       rasPrechargeCycles,
   output dtc_pkg::dtc_cyc_t       rasToCasCycles,
   output dtc_pkg::dtc_cyc_t       writeToPrechargeCycles,
   output dtc_pkg::dtc_cyc_t       refreshRasCycles,
   // Burst and bank behaviour
   output logic                    area2Burst,
   output logic                    area3Burst,
   output logic                    dramPageMode,
   output logic                    psramStaticColumn,
   output logic                    area2AutoPrecharge,
   output logic                    area3AutoPrecharge,
   // Addressing and size
   output logic [3:0]              dramColumnBits,
   output logic [2:0]              sdramGeometry,
   output logic                    longwordData,
   // Refresh
   output logic                    refreshRas,
   output logic                    selfRefreshReq,
   // Prohibited setting in the control register
   output logic                    configError
);
   import dtc_pkg::*;

   // All state of the block
   typedef struct packed {
      logic [15:0] mtc;       // Control register
      logic [31:0] rdata;     // Read data held for the access phase
      dtc_cyc_t    ras_precharge_cycles;       // Precharge cycles
      dtc_cyc_t    ras_to_cas_delay;       // RAS to CAS cycles
      dtc_cyc_t    twl;       // Write to precharge cycles
      dtc_cyc_t    tras;      // Refresh RAS cycles
      logic        burst2;    // Area 2 bursts
      logic        burst3;    // Area 3 bursts
      logic        pageMode;  // DRAM page mode on area 3
      logic        statCol;   // Pseudo-SRAM static column on area 3
      logic        autoPre2;  // Area 2 auto-precharge
      logic        autoPre3;  // Area 3 auto-precharge
      logic [3:0]  colBits;   // DRAM column address width
      logic [2:0]  geometry;  // Synchronous DRAM map code
      logic        longword;  // Longword memory
      logic        rfStart;   // Start of a normal refresh
      logic        selfRef;   // Self-refresh request
      logic        cfgErr;    // Prohibited code present
   } dtc_state_t;

   dtc_state_t st_reg;  // Registered state
   dtc_state_t st_next; // Next state

   logic addrHit;     // Address selects the control register
   logic setupPhase;  // First cycle of a transfer
   logic writeAccess; // Write completes this cycle

   ////////////////////////////////////////////////////////////////////////////
   // Decoding functions

   // Burst per area type; synchronous DRAM ignores the enable bit
   function automatic logic area_burst(input dtc_area_t kind, input logic enable);
      logic result;
      result = 1'b0;
      case (kind)
         DTC_AREA_SDRAM: result = 1'b1;
         DTC_AREA_DRAM:  result = enable;
         DTC_AREA_PSRAM: result = enable;
         default:        result = 1'b0;
      endcase
      return result;
   endfunction

   // One or two cycles from a single timing bit
   function automatic dtc_cyc_t one_or_two(input logic longSel);
      return longSel ? DTC_CYC_LONG : DTC_CYC_SHORT;
   endfunction

   // Prohibited codes for the current area 3 memory type
   function automatic logic bad_code(input logic [15:0] mtc, input dtc_area_t kind);
      logic [2:0] amx;
      logic       bad;
      amx = {mtc[DTC_BIT_ADDR_MUX_SEL_2], mtc[DTC_BIT_ADDR_MUX_SEL_1], mtc[DTC_BIT_ADDR_MUX_SEL_0]};
      bad = mtc[DTC_BIT_REFRESH_RAS_TIME_HI] && mtc[DTC_BIT_REFRESH_RAS_TIME_LO];
      if (kind == DTC_AREA_DRAM && amx[2]) begin
         bad = 1'b1;
      end
      if (kind == DTC_AREA_SDRAM && amx[2] && amx != 3'h7) begin
         bad = 1'b1;
      end
      return bad;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // APB decode: zero wait states, unmapped addresses answer with an error
   assign addrHit     = (paddr == DTC_MTC_ADDR);
   assign setupPhase  = psel && !penable;
   assign writeAccess = psel && penable && pwrite && addrHit;
   assign pready      = 1'b1;
   assign pslverr     = psel && penable && !addrHit;

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      st_next = st_reg;

      // Write lands on the access edge; reserved bits cannot be set
      if (writeAccess) begin
         st_next.mtc = pwdata[15:0] & DTC_MTC_WMASK;
      end

      // Read data captured in setup so it stands through the access phase
      if (setupPhase) begin
         st_next.rdata = (addrHit && !pwrite) ? {16'h0000, st_reg.mtc} : 32'h00000000;
      end

      // Access timing bits
      st_next.ras_precharge_cycles = one_or_two(st_reg.mtc[DTC_BIT_TRP]);
      st_next.ras_to_cas_delay = one_or_two(st_reg.mtc[DTC_BIT_RCD]);
      st_next.twl = one_or_two(st_reg.mtc[DTC_BIT_TWL]);

      // Refresh RAS length; the prohibited code falls back to the longest
      case ({st_reg.mtc[DTC_BIT_REFRESH_RAS_TIME_HI], st_reg.mtc[DTC_BIT_REFRESH_RAS_TIME_LO]})
         2'b00:   st_next.tras = DTC_RAS_CYC0;
         2'b01:   st_next.tras = DTC_RAS_CYC1;
         default: st_next.tras = DTC_RAS_CYC2;
      endcase

      // Burst behaviour per area
      st_next.burst2   = area_burst(area2Type, st_reg.mtc[DTC_BIT_BURST]);
      st_next.burst3   = area_burst(area3Type, st_reg.mtc[DTC_BIT_BURST]);
      st_next.pageMode = st_reg.mtc[DTC_BIT_BURST] && area3Type == DTC_AREA_DRAM;
      st_next.statCol  = st_reg.mtc[DTC_BIT_BURST] && area3Type == DTC_AREA_PSRAM;

      // Bank handling: only area 3 may leave the bank open
      st_next.autoPre2 = (area2Type == DTC_AREA_SDRAM);
      st_next.autoPre3 = (area3Type == DTC_AREA_SDRAM) && !st_reg.mtc[DTC_BIT_BANK];

      // Address multiplexing: column width for DRAM, map code for SDRAM
      st_next.colBits  = DTC_COL_BASE + {2'b00, st_reg.mtc[DTC_BIT_ADDR_MUX_SEL_1],
                                         st_reg.mtc[DTC_BIT_ADDR_MUX_SEL_0]};
      st_next.geometry = {st_reg.mtc[DTC_BIT_ADDR_MUX_SEL_2], st_reg.mtc[DTC_BIT_ADDR_MUX_SEL_1],
                          st_reg.mtc[DTC_BIT_ADDR_MUX_SEL_0]};
      st_next.longword = st_reg.mtc[DTC_BIT_SIZE];
      st_next.cfgErr   = bad_code(st_reg.mtc, area3Type);

      // Refresh: ticks pass only when enabled and in normal mode
      st_next.rfStart = refreshTick && st_reg.mtc[DTC_BIT_REFRESH_ENABLE]
                        && !st_reg.mtc[DTC_BIT_REFRESH_MODE_SELECT];
      st_next.selfRef = st_reg.mtc[DTC_BIT_REFRESH_ENABLE] && st_reg.mtc[DTC_BIT_REFRESH_MODE_SELECT];
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; reset values match a zeroed control register
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_reg          <= '0;
         st_reg.mtc      <= DTC_MTC_RESET;
         st_reg.ras_precharge_cycles      <= DTC_CYC_SHORT;
         st_reg.ras_to_cas_delay      <= DTC_CYC_SHORT;
         st_reg.twl      <= DTC_CYC_SHORT;
         st_reg.tras     <= DTC_RAS_CYC0;
         st_reg.colBits  <= DTC_COL_BASE;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Refresh RAS pulse generator; a tick that lands while RAS is high is
   // dropped, so an over-eager refresh timer loses ticks, RAS never stretches
   dtc_refresh_ras u_refresh_ras (
      .clk       (clk),
      .reset     (reset),
      .start     (st_reg.rfStart),
      .rasCycles (st_reg.tras),
      .rasActive (refreshRas)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Outputs from flops
   assign prdata                 = st_reg.rdata;
   assign rasPrechargeCycles     = st_reg.ras_precharge_cycles;
   assign rasToCasCycles         = st_reg.ras_to_cas_delay;
   assign writeToPrechargeCycles = st_reg.twl;
   assign refreshRasCycles       = st_reg.tras;
   assign area2Burst             = st_reg.burst2;
   assign area3Burst             = st_reg.burst3;
   assign dramPageMode           = st_reg.pageMode;
   assign psramStaticColumn      = st_reg.statCol;
   assign area2AutoPrecharge     = st_reg.autoPre2;
   assign area3AutoPrecharge     = st_reg.autoPre3;
   assign dramColumnBits         = st_reg.colBits;
   assign sdramGeometry          = st_reg.geometry;
   assign longwordData           = st_reg.longword;
   assign selfRefreshReq         = st_reg.selfRef;
   assign configError            = st_reg.cfgErr;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // Register path: masked writes, refused addresses, captured read data
   chk_write_mask: assert property (
      writeAccess |=> st_reg.mtc == ($past(pwdata[15:0]) & DTC_MTC_WMASK))
      else $error("control register write not masked");

   chk_unmapped_keep: assert property (
      (psel && penable && pwrite && !addrHit) |=> $stable(st_reg.mtc))
      else $error("unmapped write changed the register");

   chk_rdata_hit: assert property (
      (setupPhase && addrHit && !pwrite) |=> prdata == {16'h0000, $past(st_reg.mtc)})
      else $error("read data does not match the register");

   // Decoded settings track the register one clock late
   chk_ras_decode: assert property (
      refreshRasCycles == ($past(st_reg.mtc[12]) ? 3'h4
                           : 3'h2 + {2'b00, $past(st_reg.mtc[11])}))
      else $error("refresh RAS length not decoded");

   chk_geometry_map: assert property (
      sdramGeometry == {$past(st_reg.mtc[7]), $past(st_reg.mtc[5:4])})
      else $error("map code does not follow the register");

   chk_self_refresh: assert property (
      selfRefreshReq == ($past(st_reg.mtc[3]) && $past(st_reg.mtc[2])))
      else $error("self-refresh request wrong");

   // A refresh pulse only follows an enabled, normal-mode tick
   chk_refresh_gate: assert property (
      $rose(refreshRas) |-> $past(st_reg.mtc[3], 2) && !$past(st_reg.mtc[2], 2))
      else $error("refresh pulse without enabled normal refresh");

   // Plain memory never bursts; area 2 synchronous DRAM always does
   chk_normal_quiet: assert property (
      $past(area3Type) == DTC_AREA_NORMAL
         |-> !area3Burst && !dramPageMode && !psramStaticColumn)
      else $error("ordinary area shows burst behaviour");

   chk_sdram2_burst: assert property (
      $past(area2Type) == DTC_AREA_SDRAM |-> area2Burst)
      else $error("area 2 synchronous DRAM does not burst");

   chk_timing_bits: assert property (
      writeAccess |=> ##1 rasPrechargeCycles == ($past(pwdata[15], 2) ? 3'h2 : 3'h1)
                       && rasToCasCycles == ($past(pwdata[14], 2) ? 3'h2 : 3'h1)
                       && writeToPrechargeCycles == ($past(pwdata[13], 2) ? 3'h2 : 3'h1))
      else $error("timing cycles do not follow written bits");

   // Burst decodes follow the area types
   chk_sdram_burst: assert property (
      $past(area3Type) == DTC_AREA_SDRAM |-> area3Burst)
      else $error("synchronous DRAM area does not burst");
   chk_dram_burst_off: assert property (
      ($past(area2Type) == DTC_AREA_DRAM && !$past(st_reg.mtc[10])) |-> !area2Burst)
      else $error("DRAM bursts with burst bit clear");
   chk_page_mode: assert property (
      ($past(area3Type) == DTC_AREA_DRAM && $past(st_reg.mtc[10])) |-> dramPageMode && area3Burst)
      else $error("DRAM page mode missing");
   chk_static_col: assert property (
      psramStaticColumn == ($past(area3Type) == DTC_AREA_PSRAM && $past(st_reg.mtc[10])))
      else $error("static column mode wrong");

   // Bank mode: only area 3 may keep a row open
   chk_auto_pre3: assert property (
      ($past(area3Type) == DTC_AREA_SDRAM && !$past(st_reg.mtc[9])) |-> area3AutoPrecharge)
      else $error("area 3 not auto-precharged");
   chk_bank_open: assert property (
      ($past(area3Type) == DTC_AREA_SDRAM && $past(st_reg.mtc[9])) |-> !area3AutoPrecharge)
      else $error("area 3 bank not left active");
   chk_auto_pre2: assert property (
      $past(area2Type) == DTC_AREA_SDRAM |-> area2AutoPrecharge)
      else $error("area 2 not auto-precharged");

   // Addressing and data size
   chk_column_bits: assert property (
      writeAccess |=> ##1 dramColumnBits == 4'h8 + {2'b00, $past(pwdata[5:4], 2)})
      else $error("column width wrong");
   chk_geometry_err: assert property (
      (area3Type == DTC_AREA_SDRAM && st_reg.mtc[7:4] inside {4'h8, 4'h9, 4'ha, 4'hb,
       4'hc, 4'hd, 4'he, 4'hf} && st_reg.mtc[5:4] != 2'b11) |=> configError)
      else $error("prohibited map code not flagged");
   chk_data_size: assert property (
      writeAccess |=> ##1 longwordData == $past(pwdata[6], 2))
      else $error("data size does not follow bit");

   // Refresh enable and mode
   chk_refresh_off: assert property (
      !st_reg.mtc[3] |=> !st_reg.rfStart && !selfRefreshReq)
      else $error("refresh issued while disabled");
   chk_refresh_mode: assert property (
      (st_reg.mtc[3] && refreshTick) |=> (st_reg.rfStart != $past(st_reg.mtc[2]))
                                        && (selfRefreshReq == $past(st_reg.mtc[2])))
      else $error("refresh mode not honoured");

   // Reserved bits never read back as ones
   chk_reserved_zero: assert property (
      (setupPhase && addrHit && !pwrite) |=> prdata[31:16] == 16'h0000
                                             && prdata[8] == 1'b0 && prdata[1:0] == 2'b00)
      else $error("reserved bits read nonzero");

   cov_write: cover property (writeAccess);
   cov_self_refresh: cover property (selfRefreshReq);
   cov_normal_refresh: cover property (refreshRas);
   cov_bank_open: cover property (area3Burst && !area3AutoPrecharge);

endmodule

`default_nettype wire

/* dv/dtc_mem_model.sv */
// Memory-side model: watches the refresh RAS strobe the way a chip would.
// Assumes refreshRas is a registered level on the same system clock.
`timescale 1ns/1ps
`default_nettype none

module dtc_mem_model (
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // Strobe from the controller
   input  wire logic refreshRas,
   // Observations for the bench
   output var  int   pulses,
   output var  int   lastWidth
);
   int run;  // Cycles seen high in the current pulse

   ////////////////////////////////////////////////////////////////////////////
   // Count each RAS pulse and its width; a short pulse loses cells, so width matters
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         run <= 0;
         pulses <= 0;
         lastWidth <= 0;
      end else if (refreshRas === 1'b1) begin
         run <= run + 1;
      end else if (run > 0) begin
         // Pulse ended: log its length
         pulses <= pulses + 1;
         lastWidth <= run;
         run <= 0;
      end
   end
endmodule

`default_nettype wire

/* dv/dtc_timing_config_test.sv */
// Self-checking bench for the DRAM timing configuration block.
// Assumes the APB slave answers in its own time; a memory model logs refresh.
`timescale 1ns/1ps
`default_nettype none
`define CHK(N, E, G) begin nCompared++; if ((G) !== (E)) begin failCount++; \
   $display("wrong value %s expected %0h seen %0h", N, E, G); end end

module dtc_timing_config_test;
   import dtc_pkg::*;
   logic        clk, reset, psel, penable, pwrite, pready, pslverr, refreshTick;
   logic [31:0] paddr, pwdata, prdata, q;
   logic        area2Burst, area3Burst, dramPageMode, psramStaticColumn, e;
   logic        area2AutoPrecharge, area3AutoPrecharge, longwordData;
   logic        refreshRas, selfRefreshReq, configError;
   logic [3:0]  dramColumnBits;
   logic [2:0]  sdramGeometry;
   dtc_area_t   area2Type, area3Type, t;
   dtc_cyc_t    rasPrechargeCycles, rasToCasCycles, writeToPrechargeCycles;
   dtc_cyc_t    refreshRasCycles;
   int          failCount, nCompared, cycles, pulses, lastWidth, i;

   dtc_timing_config DUT (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .area2Type(area2Type), .area3Type(area3Type),
      .refreshTick(refreshTick), .rasPrechargeCycles(rasPrechargeCycles),
      .rasToCasCycles(rasToCasCycles), .writeToPrechargeCycles(writeToPrechargeCycles),
      .refreshRasCycles(refreshRasCycles), .area2Burst(area2Burst), .area3Burst(area3Burst),
      .dramPageMode(dramPageMode), .psramStaticColumn(psramStaticColumn),
      .area2AutoPrecharge(area2AutoPrecharge), .area3AutoPrecharge(area3AutoPrecharge),
      .dramColumnBits(dramColumnBits), .sdramGeometry(sdramGeometry),
      .longwordData(longwordData), .refreshRas(refreshRas),
      .selfRefreshReq(selfRefreshReq), .configError(configError));

   dtc_mem_model memModel (.clk(clk), .reset(reset), .refreshRas(refreshRas),
      .pulses(pulses), .lastWidth(lastWidth));

   ////////////////////////////////////////////////////////////////////////////
   // Clock, and a cycle ceiling well above the few hundred cycles the run needs
   always begin
      #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         failCount++;
         endOfTest();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // One APB transfer; request held until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Decoded outputs lag the register by a clock, so let two edges land
   task automatic settle;
      repeat (2) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [31:0] d);
      apb(1'b1, DTC_MTC_ADDR, d);
      settle();
   endtask

   task automatic rdchk(input logic [31:0] a, input logic [31:0] x, input logic xe);
      apb(1'b0, a, 32'h0);
      `CHK("read data", x, q)
      `CHK("slave error", xe, e)
   endtask

   // One refresh tick; expW of zero means no pulse may follow
   task automatic tick(input int expW);
      int p0;
      p0 = pulses;
      @(posedge clk);
      refreshTick <= 1'b1;
      @(posedge clk);
      refreshTick <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
      `CHK("refresh pulses", p0 + int'(expW > 0), pulses)
      if (expW > 0) `CHK("refresh width", expW, lastWidth)
   endtask

   task automatic endOfTest;
      $display("Comparisons %0d, mismatches %0d", nCompared, failCount);
      if (failCount == 0 && nCompared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      clk = 1'b0;
      reset = 1'b1;
      {psel, penable, pwrite, refreshTick} = 4'h0;
      paddr = 32'h0;
      pwdata = 32'h0;
      area2Type = DTC_AREA_NORMAL;
      area3Type = DTC_AREA_NORMAL;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      settle();
      // Reset state of register and decodes
      rdchk(DTC_MTC_ADDR, 32'h0, 1'b0);
      `CHK("precharge", 3'h1, rasPrechargeCycles)
      `CHK("ras time", 3'h2, refreshRasCycles)
      `CHK("columns", 4'h8, dramColumnBits)
      // All ones: reserved bits must stay clear
      wr(32'hffffffff);
      rdchk(DTC_MTC_ADDR, 32'h0000fefc, 1'b0);
      `CHK("precharge", 3'h2, rasPrechargeCycles)
      `CHK("ras to cas", 3'h2, rasToCasCycles)
      `CHK("write to pre", 3'h2, writeToPrechargeCycles)
      `CHK("self refresh", 1'b1, selfRefreshReq)
      tick(0);
      // Unmapped address is refused and leaves the register alone
      apb(1'b1, 32'hfffffff0, 32'h0);
      `CHK("bad write", 1'b1, e)
      rdchk(32'hfffffff0, 32'h0, 1'b1);
      rdchk(DTC_MTC_ADDR, 32'h0000fefc, 1'b0);
      // Refresh RAS width per code, then refresh switched off
      for (i = 0; i < 3; i++) begin
         wr(32'h8 | 32'(i) << 11);
         `CHK("ras time", 3'(i + 2), refreshRasCycles)
         tick(i + 2);
      end
      wr(32'h0);
      tick(0);
      // Area type against burst and bank mode bits
      for (i = 0; i < 16; i++) begin
         t = dtc_area_t'(i[1:0]);
         @(posedge clk);
         area2Type <= t;
         area3Type <= t;
         wr(32'(i[2]) << 10 | 32'(i[3]) << 9);
         `CHK("burst 3", (t == DTC_AREA_SDRAM) | (i[2] & t != DTC_AREA_NORMAL), area3Burst)
         `CHK("burst 2", (t == DTC_AREA_SDRAM) | (i[2] & t != DTC_AREA_NORMAL), area2Burst)
         `CHK("page mode", i[2] & (t == DTC_AREA_DRAM), dramPageMode)
         `CHK("static col", i[2] & (t == DTC_AREA_PSRAM), psramStaticColumn)
         `CHK("autopre 3", (t == DTC_AREA_SDRAM) & !i[3], area3AutoPrecharge)
         `CHK("autopre 2", t == DTC_AREA_SDRAM, area2AutoPrecharge)
      end
      // Column widths with the size bit toggled; area 3 becomes synchronous DRAM
      @(posedge clk);
      area3Type <= DTC_AREA_SDRAM;
      for (i = 0; i < 4; i++) begin
         wr(32'(i) << 4 | 32'(i[0]) << 6);
         `CHK("columns", 4'(8 + i), dramColumnBits)
         `CHK("geometry", 3'(i), sdramGeometry)
         `CHK("longword", i[0], longwordData)
      end
      wr(32'hb0);
      `CHK("geometry", 3'h7, sdramGeometry)
      `CHK("bad config", 1'b0, configError)
      wr(32'h80);
      `CHK("bad config", 1'b1, configError)
      @(posedge clk);
      area3Type <= DTC_AREA_DRAM;
      settle();
      `CHK("bad config", 1'b1, configError)
      endOfTest();
   end
endmodule

`default_nettype wire
